// File: rtl/idmc_ctrl.sv
// interrupt pin detection, pending and mask handling
//
// Summary of operation
// [RL1] save mask to slot on hardware service
// [RL2] then optionally clear mask; nmi unaffected
// [RL3] two-bit field picks mask clear action
// [RL4] simultaneous dedicated and expanded counts expanded
// [RL5] priority-31 may preempt priority-31 handler
// [RL6] software selects save-and-clear for expanded priority-31
// [RL7] return never restores mask from slot
// [RL8] two-bit field selects pin mode
// [RL9] per-pin level or edge; fixed for others
// [RL10] edge pin: falling transition sets pending
// [RL11] level pin sets pending; pending is sticky
// [RL12] service clears pending; active level re-sets
// [RL13] handler clears level source before return
// [RL14] global bit picks debounce; expanded always debounced
// [RL15] debounce needs stable low several clocks
// [RL16] synchronise inputs, sample every second clock
// [RL17] global enable gates pins and dma
// [RL18] vector cache bit; only low nibble 0010
// [RL19] bit holds dma during interrupt invocation
// [RL20] software writes zero to upper sixteen bits
// [RL21] control register loaded at init or reload
// [RL22] bits 0-7 pins, 8-11 dma
// [RL23] mask resets zero; pending kept on warm
// [RL24] mixed: pins 0-4 expanded, low bits 010
// [RL25] mask bit zero disables its source
// [RL26] mode and mask-op encodings fixed
// [RL27] debounce is three consecutive low samples
`timescale 1ns/1ps
`include "idmc_cfg.svh"

module idmc_ctrl (
	input wire logic clk, // 25 MHz processor clock
	input wire logic reset_n, // synchronous reset
	input wire logic cold_start, // with reset: also clear pending
	input wire logic [7:0] ext_req_n, // external request pins
	input wire logic nmi_req_n, // non-maskable request pin
	input wire logic [3:0] dma_req, // dma channel request pulses
	input wire logic cfg_load, // load control register
	input wire logic [31:0] cfg_data, // control register value
	input wire logic mask_wr, // software mask write
	input wire logic [11:0] mask_wdata, // mask write data
	input wire logic pend_wr, // software pending write
	input wire logic [11:0] pend_wdata, // pending write data
	input wire logic srv, // hardware interrupt service pulse
	input wire logic srv_ded, // service includes dedicated source
	input wire logic srv_exp, // service includes expanded source
	input wire logic [3:0] srv_idx, // dedicated source being served
	input wire logic invoking, // interrupt procedure being called
	output logic [31:0] interrupt_control_config, // control register
	output logic [11:0] interrupt_mask, // mask register
	output logic [11:0] interrupt_pending, // pending register
	output logic [11:0] saved_mask_slot, // mask saved on service
	output logic hw_request, // unmasked dedicated request
	output logic [7:0] exp_vector, // expanded vector number
	output logic exp_valid, // expanded request, unmasked
	output logic nmi_event, // non-maskable event pulse
	output logic vector_cache_select, // vectors from internal memory
	output logic vec_cacheable, // expanded vector may be cached
	output logic dma_hold // suspend dma now
);
	idmc_pkg::idmc_mode_t mode;
	idmc_pkg::idmc_mop_t mop;
	logic [8:0] sync1;
	logic [8:0] sync2;
	logic [8:0] hist0;
	logic [8:0] hist1;
	logic [8:0] hist2;
	logic [8:0] prev_det;
	logic [8:0] det;
	logic [8:0] deb_sel;
	logic [8:0] fall;
	logic [7:0] ded;
	logic [11:0] set_vec;
	logic [11:0] clr_vec;
	logic [11:0] next_pending;
	logic sample_en;
	logic gie;
	logic clr_now;

	// pins owned by dedicated logic for a mode
	function automatic logic [7:0] ded_pins(input idmc_pkg::idmc_mode_t m);
		logic [7:0] r;
		r = `IDMC_NO_DED;
		unique case (m)
			idmc_pkg::IDMC_DEDICATED: r = `IDMC_ALL_DED;
			idmc_pkg::IDMC_MIXED: r = `IDMC_MIXED_DED; // RL24
			idmc_pkg::IDMC_EXPANDED: r = `IDMC_NO_DED;
			default: r = `IDMC_NO_DED;
		endcase
		return r;
	endfunction : ded_pins

	assign mode = idmc_pkg::idmc_mode_t'(interrupt_control_config[`IDMC_MODE_LSB +: 2]); // RL8 RL26
	assign mop = idmc_pkg::idmc_mop_t'(interrupt_control_config[`IDMC_MOP_LSB +: 2]); // RL26
	assign gie = interrupt_control_config[`IDMC_GIE_BIT];
	assign ded = ded_pins(mode);
	assign vector_cache_select = interrupt_control_config[`IDMC_VCE_BIT];
	assign dma_hold = interrupt_control_config[`IDMC_DMAS_BIT] & invoking; // RL19

	// control register: loaded from the table at init and on reload
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			interrupt_control_config <= `IDMC_CFG_RESET;
		end else if (cfg_load) begin
			interrupt_control_config <= cfg_data; // RL21
		end
	end

	// two-stage synchroniser; first stage feeds nothing else
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync1 <= `IDMC_PIN_IDLE;
			sync2 <= `IDMC_PIN_IDLE;
		end else begin
			sync1 <= {nmi_req_n, ext_req_n}; // RL16
			sync2 <= sync1;
		end
	end

	// one sample every second clock edge
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sample_en <= 1'b0;
		end else begin
			sample_en <= ~sample_en; // RL16
		end
	end

	// low-level history; bit set means low was sampled
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hist0 <= 9'h000;
			hist1 <= 9'h000;
			hist2 <= 9'h000;
			prev_det <= 9'h000;
		end else if (sample_en) begin
			hist0 <= ~sync2;
			hist1 <= hist0;
			hist2 <= hist1; // RL27
			prev_det <= det;
		end
	end

	// expanded pins ignore the global choice and always debounce
	always_comb begin
		deb_sel[7:0] = ~ded; // RL14
		deb_sel[`IDMC_NMI_IDX] = 1'b0;
		if (interrupt_control_config[`IDMC_SAMP_BIT] == `IDMC_SAMP_DEBOUNCE) begin
			deb_sel = 9'h1ff; // RL14
		end
		det = (deb_sel & hist0 & hist1 & hist2) | (~deb_sel & hist0); // RL15 RL27
		fall = det & ~prev_det & {9{sample_en}};
	end

	// nmi is always edge detected and never masked
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			nmi_event <= 1'b0;
		end else begin
			nmi_event <= fall[`IDMC_NMI_IDX]; // RL9
		end
	end

	// pending sets: edge or level per dedicated pin, dma pulses
	always_comb begin
		set_vec = {dma_req, 8'h00}; // RL22
		for (int i = 0; i < `IDMC_NPINS; i++) begin
			if (interrupt_control_config[`IDMC_DET_LSB + i] == `IDMC_DET_EDGE) begin
				set_vec[i] = ded[i] & fall[i]; // RL10
			end else begin
				set_vec[i] = ded[i] & det[i]; // RL9 RL11
			end
		end
		clr_vec = 12'h000;
		clr_now = srv & srv_ded & (srv_idx < 4'(`IDMC_NSRC));
		if (clr_now) begin
			clr_vec[srv_idx] = 1'b1; // RL12
		end
		next_pending = interrupt_pending;
		if (pend_wr) begin
			next_pending = pend_wdata;
		end
		next_pending = (next_pending & ~clr_vec) | set_vec; // RL11 RL12
	end

	// pending is not touched by a warm reset
	always_ff @(posedge clk) begin
		if (!reset_n && cold_start) begin
			interrupt_pending <= `IDMC_PEND_RESET;
		end else if (reset_n) begin
			interrupt_pending <= next_pending; // RL23
		end
	end

	// mask: saved then cleared by the mask-op field on service
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			interrupt_mask <= `IDMC_MASK_RESET; // RL23
			saved_mask_slot <= `IDMC_MASK_RESET;
		end else if (srv) begin
			saved_mask_slot <= interrupt_mask; // RL1
			unique case (mop)
				idmc_pkg::IDMC_MOP_KEEP: interrupt_mask <= interrupt_mask; // RL3
				idmc_pkg::IDMC_MOP_DED: begin
					if (srv_ded && !srv_exp) begin
						interrupt_mask <= `IDMC_MASK_RESET; // RL2 RL4
					end
				end
				idmc_pkg::IDMC_MOP_EXP: begin
					if (srv_exp) begin
						interrupt_mask <= `IDMC_MASK_RESET; // RL2 RL4
					end
				end
				idmc_pkg::IDMC_MOP_BOTH: interrupt_mask <= `IDMC_MASK_RESET; // RL2
			endcase
		end else if (mask_wr) begin
			// only software restores the mask after return
			interrupt_mask <= mask_wdata; // RL7
		end
	end

	// expanded vector from debounced pins
	always_comb begin
		exp_vector = 8'h00;
		if (mode == idmc_pkg::IDMC_EXPANDED) begin
			exp_vector = det[7:0];
		end else if (mode == idmc_pkg::IDMC_MIXED) begin
			exp_vector = {det[4:0], `IDMC_MIXED_LOW}; // RL24
		end
	end

	// no in-service lockout here, so a level-31 request can preempt
	assign exp_valid = gie & interrupt_mask[0] & (exp_vector >= `IDMC_VEC_MIN); // RL5 RL17 RL25
	assign hw_request = gie & |(interrupt_pending & interrupt_mask); // RL17 RL25
	assign vec_cacheable = vector_cache_select & (exp_vector[3:0] == `IDMC_CACHE_NIB); // RL18

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	chk_save_mask: assert property (srv |=> saved_mask_slot == $past(interrupt_mask)) // RL1
		else $error("mask not saved on service");
	chk_clear_both: assert property (srv && mop == idmc_pkg::IDMC_MOP_BOTH |=> interrupt_mask == 12'h000) // RL2
		else $error("mask not cleared");
	chk_keep_mask: assert property (srv && mop == idmc_pkg::IDMC_MOP_KEEP |=> $stable(interrupt_mask)) // RL3
		else $error("mask changed with keep option");
	chk_exp_wins: assert property (srv && srv_ded && srv_exp && mop == idmc_pkg::IDMC_MOP_DED // RL4
		|=> $stable(interrupt_mask))
		else $error("mixed service handled as dedicated");
	chk_no_restore: assert property (!srv && !mask_wr |=> $stable(interrupt_mask)) // RL7
		else $error("mask changed without write");
	chk_pend_set: assert property (set_vec != 12'h000 // RL10
		|=> (interrupt_pending & $past(set_vec)) == $past(set_vec))
		else $error("pending bit not set");
	chk_pend_sticky: assert property (!pend_wr && !clr_now // RL11
		|=> (interrupt_pending & $past(interrupt_pending)) == $past(interrupt_pending))
		else $error("pending bit dropped");
	chk_srv_clear: assert property (clr_now && !pend_wr && set_vec[srv_idx] == 1'b0 // RL12
		|=> interrupt_pending[$past(srv_idx)] == 1'b0)
		else $error("served pending bit not cleared");
	chk_sample_rate: assert property (sample_en |=> !sample_en ##1 sample_en) // RL16
		else $error("sampling not every second clock");
	chk_gie_gate: assert property (!gie |-> !hw_request && !exp_valid) // RL17
		else $error("request passed global disable");
	chk_nmi_pulse: assert property (nmi_event |=> !nmi_event) // RL9
		else $error("nmi event longer than one cycle");
	chk_cache_nib: assert property (vec_cacheable |-> exp_vector[3:0] == `IDMC_CACHE_NIB) // RL18
		else $error("uncacheable vector flagged");
	chk_mop_ded: assert property (srv && srv_ded && !srv_exp && mop == idmc_pkg::IDMC_MOP_DED // RL3
		|=> interrupt_mask == `IDMC_MASK_RESET)
		else $error("mask not cleared on dedicated service");
	chk_mop_exp: assert property (srv && srv_exp && mop == idmc_pkg::IDMC_MOP_EXP // RL3 RL4
		|=> interrupt_mask == `IDMC_MASK_RESET)
		else $error("mask not cleared on expanded service");
	chk_mop_exp_keep: assert property (srv && !srv_exp && mop == idmc_pkg::IDMC_MOP_EXP // RL3
		|=> $stable(interrupt_mask))
		else $error("mask cleared on dedicated service");
	chk_cfg_load: assert property (cfg_load |=> interrupt_control_config == $past(cfg_data)) // RL21
		else $error("control register not loaded");
	chk_dma_pend: assert property (dma_req != 4'h0 // RL22
		|=> (interrupt_pending[11:8] & $past(dma_req)) == $past(dma_req))
		else $error("dma request not posted");
	chk_exp_unposted: assert property (mode == idmc_pkg::IDMC_EXPANDED && !pend_wr // RL9
		|=> (interrupt_pending[7:0] & ~$past(interrupt_pending[7:0])) == 8'h00)
		else $error("expanded pin posted a pending bit");
	chk_mixed_low: assert property (mode == idmc_pkg::IDMC_MIXED |-> exp_vector[2:0] == `IDMC_MIXED_LOW) // RL24
		else $error("mixed vector low bits wrong");
	chk_pend_write: assert property (pend_wr && !clr_now && set_vec == 12'h000 // RL11
		|=> interrupt_pending == $past(pend_wdata))
		else $error("pending write lost");
	// these two watch the reset itself, so it must not disable them
	chk_mask_reset: assert property (disable iff (1'b0) !reset_n // RL23
		|=> interrupt_mask == `IDMC_MASK_RESET)
		else $error("mask not cleared by reset");
	chk_warm_keep: assert property (disable iff (1'b0) !reset_n && !cold_start // RL23
		|=> $stable(interrupt_pending))
		else $error("pending lost on warm reset");

	cov_exp_service: cover property (exp_valid ##[1:20] srv && srv_exp);
	cov_ded_service: cover property (hw_request ##[1:20] clr_now);
	cov_nmi: cover property (nmi_event);
	cov_mixed: cover property (mode == idmc_pkg::IDMC_MIXED && exp_valid);
endmodule : idmc_ctrl

// File: rtl/idmc_cfg.svh
// constants for the interrupt detect and mask block
`ifndef IDMC_CFG_SVH
`define IDMC_CFG_SVH
`define IDMC_CFG_RESET 32'h0000_0000
`define IDMC_MASK_RESET 12'h000
`define IDMC_PEND_RESET 12'h000
`define IDMC_NPINS 8
`define IDMC_NSRC 12
`define IDMC_MODE_LSB 0
`define IDMC_DET_LSB 2
`define IDMC_GIE_BIT 10
`define IDMC_MOP_LSB 11
`define IDMC_VCE_BIT 13
`define IDMC_SAMP_BIT 14
`define IDMC_DMAS_BIT 15
`define IDMC_SAMP_DEBOUNCE 1'h0
`define IDMC_DET_EDGE 1'h1
`define IDMC_MIXED_LOW 3'h2
`define IDMC_CACHE_NIB 4'h2
`define IDMC_VEC_MIN 8'h08
`define IDMC_NMI_IDX 8
`define IDMC_PIN_IDLE 9'h1ff
`define IDMC_ALL_DED 8'hff
`define IDMC_MIXED_DED 8'he0
`define IDMC_NO_DED 8'h00
`endif

// File: rtl/idmc_pkg.sv
// types for the interrupt detect and mask block
package idmc_pkg;
	typedef enum logic [1:0] {
		IDMC_DEDICATED = 2'b00,
		IDMC_EXPANDED = 2'b01,
		IDMC_MIXED = 2'b10,
		IDMC_MODE_RSVD = 2'b11
	} idmc_mode_t;
	typedef enum logic [1:0] {
		IDMC_MOP_KEEP = 2'b00,
		IDMC_MOP_DED = 2'b01,
		IDMC_MOP_EXP = 2'b10,
		IDMC_MOP_BOTH = 2'b11
	} idmc_mop_t;
endpackage : idmc_pkg

// File: bench/idmc_src_model.sv
// external interrupt source model driving the request pins
`timescale 1ns/1ps
module idmc_src_model (
	input wire logic clk, // processor clock
	input wire logic [7:0] active, // asserted sources, or expanded vector
	input wire logic nmi_fire, // hold nmi low while high
	output logic [7:0] ext_req_n = 8'hff, // request pins, idle high by pull-up
	output logic nmi_req_n = 1'b1 // nmi pin
);
	// pins move just after the falling edge, after the bench has set them, so no race
	// a level source stays until told to drop
	always @(negedge clk) begin
		#1;
		ext_req_n <= ~active;
		nmi_req_n <= ~nmi_fire;
	end
endmodule : idmc_src_model

// File: bench/tb_top.sv
// self-checking testbench for the interrupt detect and mask block
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, reset_n = 0, cold_start = 1, cfg_load = 0, mask_wr = 0, pend_wr = 0;
	logic srv = 0, srv_ded = 0, srv_exp = 0, invoking = 0, nmi_fire = 0;
	logic [3:0] dma_req = 0, srv_idx = 0;
	logic [31:0] cfg_data = 0, m_cfg = 0, v, seed = 32'h0000_d95a;
	logic [11:0] mask_wdata = 0, pend_wdata = 0, m_mask = 0, m_slot = 0;
	logic [7:0] active = 0, ext_req_n, exp_vector;
	logic nmi_req_n, hw_request, exp_valid, nmi_event, vector_cache_select, vec_cacheable, dma_hold;
	logic [31:0] interrupt_control_config;
	logic [11:0] interrupt_mask, interrupt_pending, saved_mask_slot;
	int n_mismatch = 0, num_checks = 0;
	always #20 clk = ~clk;
	idmc_src_model u_idmc_src_model (.clk, .active, .nmi_fire, .ext_req_n, .nmi_req_n);
	idmc_ctrl u_idmc_ctrl (.clk, .reset_n, .cold_start, .ext_req_n, .nmi_req_n, .dma_req, .cfg_load,
		.cfg_data, .mask_wr, .mask_wdata, .pend_wr, .pend_wdata, .srv, .srv_ded, .srv_exp, .srv_idx,
		.invoking, .interrupt_control_config, .interrupt_mask, .interrupt_pending, .saved_mask_slot,
		.hw_request, .exp_vector, .exp_valid, .nmi_event, .vector_cache_select, .vec_cacheable, .dma_hold);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic load_cfg(input logic [31:0] d);
		cfg_load = 1;
		cfg_data = d;
		m_cfg = d;
		cyc(1);
		cfg_load = 0;
		cyc(1);
	endtask : load_cfg
	task automatic wr_mask(input logic [11:0] d);
		mask_wr = 1;
		mask_wdata = d;
		m_mask = d;
		cyc(1);
		mask_wr = 0;
		cyc(1);
	endtask : wr_mask
	task automatic service(input logic d, input logic e, input logic [3:0] idx);
		logic [1:0] op;
		op = m_cfg[12:11];
		srv = 1;
		srv_ded = d;
		srv_exp = e;
		srv_idx = idx;
		m_slot = m_mask;
		// both kinds at once count as expanded, so a dedicated-only clear is skipped
		if ((op == 2'h3 && (d || e)) || (op == 2'h2 && e) || (op == 2'h1 && d && !e)) m_mask = 0;
		cyc(1);
		srv = 0;
		cyc(1);
		chk("saved_mask_slot", m_slot, saved_mask_slot);
		chk("interrupt_mask", m_mask, interrupt_mask);
	endtask : service
	task automatic wait_pend(input int b);
		for (int i = 0; i < 40 && interrupt_pending[b] !== 1'b1; i++) cyc(1);
		chk("pending bit", 1, interrupt_pending[b]);
	endtask : wait_pend
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		cyc(5);
		reset_n = 1;
		chk("config", 0, interrupt_control_config);
		chk("interrupt_mask", 0, interrupt_mask);
		chk("interrupt_pending", 0, interrupt_pending);
		for (int i = 0; i < 6; i++) begin
			v = xs() & 32'h0000_ffff;
			invoking = seed[20];
			load_cfg(v);
			chk("config", v, interrupt_control_config);
			chk("vector_cache_select", v[13], vector_cache_select);
			chk("dma_hold", v[15] & invoking, dma_hold);
		end
		invoking = 0;
		// fast sampling, pin 7 edge, others level, enabled, clear on both kinds
		load_cfg(32'h0000_5e00);
		wr_mask(12'hfff);
		active = 8'h88;
		wait_pend(7);
		wait_pend(3);
		chk("hw_request", 1, hw_request);
		service(1, 0, 7);
		chk("edge pending", 0, interrupt_pending[7]);
		service(1, 0, 3);
		chk("level pending", 1, interrupt_pending[3]);
		active = 0;
		cyc(12);
		chk("sticky pending", 8'h08, interrupt_pending[7:0]);
		pend_wr = 1;
		pend_wdata = 0;
		cyc(1);
		pend_wr = 0;
		dma_req = 4'h2;
		cyc(1);
		dma_req = 0;
		cyc(1);
		chk("dma pending", 12'h200, interrupt_pending);
		chk("hw_request", 0, hw_request);
		wr_mask(12'h200);
		chk("hw_request", 1, hw_request);
		load_cfg(32'h0000_4200);
		chk("hw_request", 0, hw_request);
		for (int op = 0; op < 4; op++) begin
			for (int k = 1; k < 4; k++) begin
				load_cfg({19'h0, op[1:0], 11'h400});
				wr_mask((xs() & 12'hfff) | 12'h001);
				service(k[0], k[1], 4'hf);
			end
		end
		// expanded mode: vector inverted onto pins, always debounced, vector flagged cacheable
		load_cfg(32'h0000_3c01);
		wr_mask(12'h001);
		active = 8'h42;
		for (int i = 0; i < 40 && exp_valid !== 1'b1; i++) cyc(1);
		chk("exp_valid", 1, exp_valid);
		chk("exp_vector", 8'h42, exp_vector);
		chk("vec_cacheable", 1, vec_cacheable);
		active = 0;
		// mixed: pins 0-4 give vector 0x2a, pin 5 a level source, clear on dedicated only
		load_cfg(32'h0000_2c02);
		wr_mask(12'h021);
		active = 8'h25;
		wait_pend(5);
		chk("exp_vector", 8'h2a, exp_vector);
		chk("exp_valid", 1, exp_valid);
		chk("vec_cacheable", 0, vec_cacheable);
		service(1, 1, 5);
		chk("level pending", 1, interrupt_pending[5]);
		service(1, 0, 5);
		chk("exp_valid", 0, exp_valid);
		active = 0;
		// warm reset keeps pending, clears mask and config
		v = {20'h0_0000, interrupt_pending};
		cold_start = 0;
		reset_n = 0;
		cyc(2);
		reset_n = 1;
		m_mask = 0;
		chk("warm pending", v[11:0], interrupt_pending);
		chk("interrupt_mask", m_mask, interrupt_mask);
		chk("config", 0, interrupt_control_config);
		cyc(2);
		chk("warm pending", v[11:0], interrupt_pending);
		load_cfg(32'h0000_4000);
		nmi_fire = 1;
		for (int i = 0; i < 40 && nmi_event !== 1'b1; i++) cyc(1);
		chk("nmi_event", 1, nmi_event);
		cyc(1);
		chk("nmi_event", 0, nmi_event);
		nmi_fire = 0;
		cyc(4);
		complete_run();
	end
endmodule : tb_top
